// ---- pkg/ssp_pkg.sv ----
/*
 * Shared constants, enumerations and helpers for the serial port
 * supervision block. Assumes a single 125 MHz core clock.
 */
package ssp_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int unsigned NPORT = 5;
   localparam int unsigned P_LOCAL = 0;
   localparam int unsigned P_REM1 = 1;
   localparam int unsigned P_REM2 = 2;
   localparam int unsigned P_REM3 = 3;
   localparam int unsigned P_FBUS = 4;
   localparam int unsigned HOLD_MIN_MS = 60_000;
   localparam int unsigned SEC_MS = 1_000;
   localparam int unsigned BAUD_MIN = 300;
   localparam int unsigned TMR_W = 20;
   localparam int unsigned GAP_W = 16;
   localparam int unsigned FAIL_S_W = 10;
   localparam int unsigned PW_W = 4;
   localparam int unsigned DIV_W = 20;
   localparam int unsigned CHG_W = 16;
   localparam int unsigned Q_DEPTH = 16;
   localparam int unsigned OPQ_DEPTH = 115;
   localparam int unsigned OPA_W = 7;

   typedef enum logic [2:0] {
      BAUD_300 = 3'h0, BAUD_600 = 3'h1, BAUD_1200 = 3'h2,
      BAUD_2400 = 3'h3, BAUD_4800 = 3'h4, BAUD_9600 = 3'h5,
      BAUD_19200 = 3'h6, BAUD_38400 = 3'h7
   } ssp_baud_e;
   typedef enum logic [1:0] {
      PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2
   } ssp_par_e;
   typedef enum logic [2:0] {
      PR_SUBST = 3'h0, PR_DNP = 3'h1, PR_POLL = 3'h2, PR_VIO = 3'h3,
      PR_FBUS = 3'h4
   } ssp_proto_e;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3,
      RX_STOP = 3'h4
   } ssp_rx_state_e;

   localparam ssp_baud_e BAUD_RST = BAUD_38400;
   localparam ssp_par_e PAR_RST = PAR_NONE;
   localparam logic STOP2_RST = 1'b0;

   // rates are 300 doubled per code step
   function automatic logic [DIV_W-1:0] baud_div(input ssp_baud_e b);
      int unsigned rate;
      rate = BAUD_MIN << b;
      return DIV_W'(CLK_HZ / rate);
   endfunction

   function automatic logic [TMR_W-1:0] hold_limit(input ssp_proto_e p,
         input logic [PW_W-1:0] pw_min);
      if (p == PR_SUBST)
         return TMR_W'(pw_min) * TMR_W'(HOLD_MIN_MS);
      return TMR_W'(HOLD_MIN_MS);
   endfunction
endpackage

// ---- core/ssp_uart_rx.sv ----
/*
 * Local port character receiver with inter-character gap supervision.
 * Assumes i_rxd synchronous to the core clock and a one-cycle ms tick.
 */
`timescale 1ns/1ps
module ssp_uart_rx
   import ssp_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_ms_tick,
   input wire logic i_rxd,
   input wire ssp_baud_e i_baud,
   input wire ssp_par_e i_parity,
   input wire logic i_two_stop,
   input wire logic [GAP_W-1:0] i_gap_ms,
   input wire logic i_msg_done,
   output logic [7:0] o_data,
   output logic o_valid,
   output logic o_par_err,
   output logic o_frame_err,
   output logic o_msg_active,
   output logic o_msg_abort
);
   ssp_rx_state_e st_q, st_d;
   logic [DIV_W-1:0] cnt_q, cnt_d, div_w;
   logic [2:0] nbit_q, nbit_d;
   logic [7:0] sh_q, sh_d;
   logic perr_q, perr_d, ferr_q, ferr_d, stop2_q, stop2_d;
   logic valid_q, valid_d;
   logic msg_q, msg_d, abort_q, abort_d;
   logic [GAP_W-1:0] gap_q, gap_d;

   assign div_w = baud_div(i_baud); // [RQ5]

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      nbit_d = nbit_q;
      sh_d = sh_q;
      perr_d = perr_q;
      ferr_d = ferr_q;
      stop2_d = stop2_q;
      valid_d = 1'b0;
      if (cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
      unique case (st_q)
         RX_IDLE: if (!i_rxd) begin
            st_d = RX_START;
            cnt_d = div_w >> 1;
            perr_d = 1'b0;
            ferr_d = 1'b0;
            stop2_d = 1'b0;
         end
         RX_START: if (cnt_q == '0) begin
            if (!i_rxd) begin
               st_d = RX_DATA;
               cnt_d = div_w - 1'b1;
               nbit_d = '0;
            end else begin
               st_d = RX_IDLE;
            end
         end
         RX_DATA: if (cnt_q == '0) begin
            sh_d = {i_rxd, sh_q[7:1]};
            cnt_d = div_w - 1'b1;
            nbit_d = nbit_q + 1'b1;
            if (nbit_q == 3'h7)
               st_d = (i_parity == PAR_NONE) ? RX_STOP : RX_PAR; // [RQ7]
         end
         RX_PAR: if (cnt_q == '0) begin
            perr_d = ((^sh_q) ^ i_rxd) != (i_parity == PAR_ODD); // [RQ7]
            cnt_d = div_w - 1'b1;
            st_d = RX_STOP;
         end
         RX_STOP: if (cnt_q == '0) begin
            if (!i_rxd)
               ferr_d = 1'b1;
            if (i_two_stop && !stop2_q) begin // [RQ6]
               stop2_d = 1'b1;
               cnt_d = div_w - 1'b1;
            end else begin
               st_d = RX_IDLE;
               valid_d = 1'b1;
            end
         end
         default: st_d = RX_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= RX_IDLE;
         cnt_q <= '0;
         nbit_q <= '0;
         sh_q <= '0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         stop2_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         nbit_q <= nbit_d;
         sh_q <= sh_d;
         perr_q <= perr_d;
         ferr_q <= ferr_d;
         stop2_q <= stop2_d;
         valid_q <= valid_d;
      end
   end

   // gap timer runs from the end of each character while a message is open
   always_comb begin
      msg_d = msg_q;
      gap_d = gap_q;
      abort_d = 1'b0;
      if (valid_q) begin
         msg_d = 1'b1;
         gap_d = '0;
      end else if (i_msg_done) begin
         msg_d = 1'b0;
         gap_d = '0;
      end else if (msg_q && gap_q > i_gap_ms) begin // [RQ8]
         msg_d = 1'b0;
         abort_d = 1'b1;
         gap_d = '0;
      end else if (msg_q && i_ms_tick && gap_q != '1) begin
         gap_d = gap_q + 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         msg_q <= 1'b0;
         gap_q <= '0;
         abort_q <= 1'b0;
      end else begin
         msg_q <= msg_d;
         gap_q <= gap_d;
         abort_q <= abort_d;
      end
   end

   assign o_data = sh_q;
   assign o_valid = valid_q;
   assign o_par_err = perr_q;
   assign o_frame_err = ferr_q;
   assign o_msg_active = msg_q;
   assign o_msg_abort = abort_q;

   default clocking rx_cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   a_gap_abort: assert property (msg_q && !valid_q && !i_msg_done && // [RQ8]
         gap_q > i_gap_ms |=> abort_q && !msg_q)
      else $error("gap over setting did not cancel message");
   a_two_stop_bits: assert property (st_q == RX_STOP && cnt_q == '0 && // [RQ6]
         i_two_stop && !stop2_q |=> st_q == RX_STOP && !valid_q)
      else $error("second stop bit skipped");
endmodule

// ---- core/ssp_top.sv ----
/*
 * Serial port supervision: local receiver, activity codes, inactivity
 * alarms, per-port change queues and operator copy.
 * Assumes all inputs synchronous to i_core_clk; settings are levels.
 */
`timescale 1ns/1ps
//
// Overview of operation
// RQ1: each serial port with traffic lights its own activity code.
// RQ2: substation-control ports hold the code for the password timeout.
// RQ3: other protocols and the field bus hold the code one minute.
// RQ4: per-port inactivity timer raises failure alarm and event.
// RQ5: local baud rate selectable 300 to 38400, 38400 after reset.
// RQ6: local frame selects one or two stop bits.
// RQ7: local parity even, odd or none, none after reset.
// RQ8: inter-character gap beyond setting cancels the message in progress.
// RQ9: failure time settable 0 to 600 seconds between messages.
// RQ10: all ports work concurrently and independently.
// RQ11: each port has its own change queue; draining one spares others.
// RQ12: operator copy of selected changes, up to 115 records.
// RQ13: operator copy is read newest change first.
// RQ14: register-polling ports report present values, keep no history.
// RQ15: local port always runs substation control; remotes configured.
// RQ16: valid message restarts timer, clears alarm, emits recovery event.
module ssp_top
   import ssp_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
)(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_cfg_load,
   input wire ssp_baud_e i_local_baud,
   input wire ssp_par_e i_local_parity,
   input wire logic i_local_two_stop,
   input wire logic [GAP_W-1:0] i_char_gap_ms,
   input wire logic i_local_rxd,
   input wire logic i_local_msg_done,
   input wire ssp_proto_e i_remote1_proto,
   input wire ssp_proto_e i_remote2_proto,
   input wire ssp_proto_e i_remote3_proto,
   input wire logic [PW_W-1:0] i_pw_timeout_min,
   input wire logic [NPORT-1:0][FAIL_S_W-1:0] i_fail_time_s,
   input wire logic [NPORT-1:0] i_port_act,
   input wire logic [NPORT-1:0] i_port_msg_ok,
   input wire logic i_chg_valid,
   input wire logic [CHG_W-1:0] i_chg_data,
   input wire logic i_chg_display,
   input wire logic [NPORT-1:0] i_q_pop,
   input wire logic [CHG_W-1:0] i_sig_value,
   input wire logic [OPA_W-1:0] i_op_rd_idx,
   input wire logic i_op_clear,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_rx_par_err,
   output logic o_rx_frame_err,
   output logic o_msg_abort,
   output logic o_local_activity_code,
   output logic o_remote1_activity_code,
   output logic o_remote2_activity_code,
   output logic o_remote3_activity_code,
   output logic o_fieldbus_activity_code,
   output logic [NPORT-1:0] o_comm_fail,
   output logic [NPORT-1:0] o_fail_event,
   output logic [NPORT-1:0] o_recover_event,
   output logic [NPORT-1:0][CHG_W-1:0] o_q_data,
   output logic [NPORT-1:0] o_q_empty,
   output logic [CHG_W-1:0] o_poll_value,
   output logic [CHG_W-1:0] o_op_data,
   output logic [OPA_W-1:0] o_op_count
);
   localparam int unsigned TICK_W = (CYC_MS > 1) ? $clog2(CYC_MS) : 1;
   localparam int unsigned QA_W = $clog2(Q_DEPTH);

   logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
   logic ms_tick_q, ms_tick_d;
   ssp_baud_e baud_q, baud_d;
   ssp_par_e par_q, par_d;
   logic stop2_q, stop2_d;
   logic rx_valid, msg_active;
   logic [NPORT-1:0] act_w, msg_ok_w;
   ssp_proto_e proto_w [NPORT];
   logic [TMR_W-1:0] hold_q [NPORT];
   logic [TMR_W-1:0] hold_d [NPORT];
   logic [TMR_W-1:0] fcnt_q [NPORT];
   logic [TMR_W-1:0] fcnt_d [NPORT];
   logic [TMR_W-1:0] fail_lim;
   logic [NPORT-1:0] code_q, code_d, fail_q, fail_d;
   logic [NPORT-1:0] fev_q, fev_d, rev_q, rev_d;
   logic [CHG_W-1:0] q_mem [NPORT][Q_DEPTH];
   logic [QA_W:0] wp_q [NPORT];
   logic [QA_W:0] wp_d [NPORT];
   logic [QA_W:0] rp_q [NPORT];
   logic [QA_W:0] rp_d [NPORT];
   logic [NPORT-1:0] q_we;
   logic [CHG_W-1:0] op_mem [OPQ_DEPTH];
   logic [OPA_W-1:0] op_wp_q, op_wp_d, op_cnt_q, op_cnt_d;
   logic [OPA_W:0] op_addr;
   logic op_we;
   logic [CHG_W-1:0] op_data_q, op_data_d, poll_q;

   function automatic logic [QA_W:0] q_count(input logic [QA_W:0] w,
         input logic [QA_W:0] r);
      return w - r;
   endfunction

   always_comb begin
      tick_cnt_d = tick_cnt_q + 1'b1;
      ms_tick_d = 1'b0;
      if (tick_cnt_q == TICK_W'(CYC_MS - 1)) begin
         tick_cnt_d = '0;
         ms_tick_d = 1'b1;
      end
      baud_d = baud_q;
      par_d = par_q;
      stop2_d = stop2_q;
      if (i_cfg_load) begin
         baud_d = i_local_baud; // [RQ5]
         par_d = i_local_parity; // [RQ7]
         stop2_d = i_local_two_stop; // [RQ6]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_cnt_q <= '0;
         ms_tick_q <= 1'b0;
         baud_q <= BAUD_RST; // [RQ5]
         par_q <= PAR_RST; // [RQ7]
         stop2_q <= STOP2_RST;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         ms_tick_q <= ms_tick_d;
         baud_q <= baud_d;
         par_q <= par_d;
         stop2_q <= stop2_d;
      end
   end

   ssp_uart_rx u_rx (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_ms_tick(ms_tick_q),
      .i_rxd(i_local_rxd),
      .i_baud(baud_q),
      .i_parity(par_q),
      .i_two_stop(stop2_q),
      .i_gap_ms(i_char_gap_ms),
      .i_msg_done(i_local_msg_done),
      .o_data(o_rx_data),
      .o_valid(rx_valid),
      .o_par_err(o_rx_par_err),
      .o_frame_err(o_rx_frame_err),
      .o_msg_active(msg_active),
      .o_msg_abort(o_msg_abort)
   );

   assign o_rx_valid = rx_valid;
   assign act_w = i_port_act | NPORT'(rx_valid);
   assign msg_ok_w = i_port_msg_ok | NPORT'(i_local_msg_done & msg_active);

   always_comb begin
      proto_w[P_LOCAL] = PR_SUBST; // [RQ15]
      proto_w[P_REM1] = i_remote1_proto;
      proto_w[P_REM2] = i_remote2_proto;
      proto_w[P_REM3] = i_remote3_proto;
      proto_w[P_FBUS] = PR_FBUS;
   end

   // one independent timer set per port [RQ10]
   always_comb begin
      fail_lim = '0;
      for (int p = 0; p < NPORT; p++) begin
         hold_d[p] = hold_q[p];
         fcnt_d[p] = fcnt_q[p];
         fail_d[p] = fail_q[p];
         fev_d[p] = 1'b0;
         rev_d[p] = 1'b0;
         if (act_w[p])
            hold_d[p] = hold_limit(proto_w[p], i_pw_timeout_min); // [RQ2] [RQ3]
         else if (ms_tick_q && hold_q[p] != '0)
            hold_d[p] = hold_q[p] - 1'b1;
         code_d[p] = hold_d[p] != '0; // [RQ1]
         fail_lim = TMR_W'(i_fail_time_s[p]) * TMR_W'(SEC_MS); // [RQ9]
         if (msg_ok_w[p]) begin
            fcnt_d[p] = '0; // [RQ16]
            if (fail_q[p]) begin
               fail_d[p] = 1'b0;
               rev_d[p] = 1'b1;
            end
         end else if (ms_tick_q && fail_lim != '0 && !fail_q[p]) begin
            fcnt_d[p] = fcnt_q[p] + 1'b1;
            if (TMR_W'(fcnt_q[p] + 1'b1) >= fail_lim) begin // [RQ4]
               fail_d[p] = 1'b1;
               fev_d[p] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int p = 0; p < NPORT; p++) begin
            hold_q[p] <= '0;
            fcnt_q[p] <= '0;
         end
         code_q <= '0;
         fail_q <= '0;
         fev_q <= '0;
         rev_q <= '0;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            hold_q[p] <= hold_d[p];
            fcnt_q[p] <= fcnt_d[p];
         end
         code_q <= code_d;
         fail_q <= fail_d;
         fev_q <= fev_d;
         rev_q <= rev_d;
      end
   end

   assign o_local_activity_code = code_q[P_LOCAL];
   assign o_remote1_activity_code = code_q[P_REM1];
   assign o_remote2_activity_code = code_q[P_REM2];
   assign o_remote3_activity_code = code_q[P_REM3];
   assign o_fieldbus_activity_code = code_q[P_FBUS];
   assign o_comm_fail = fail_q;
   assign o_fail_event = fev_q;
   assign o_recover_event = rev_q;

   // per-port change queues; polling ports keep no history
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         wp_d[p] = wp_q[p];
         rp_d[p] = rp_q[p];
         q_we[p] = 1'b0;
         if (i_chg_valid && proto_w[p] != PR_POLL && // [RQ14]
               q_count(wp_q[p], rp_q[p]) != (QA_W+1)'(Q_DEPTH)) begin
            q_we[p] = 1'b1; // [RQ11]
            wp_d[p] = wp_q[p] + 1'b1;
         end
         if (i_q_pop[p] && q_count(wp_q[p], rp_q[p]) != '0)
            rp_d[p] = rp_q[p] + 1'b1; // [RQ11]
         o_q_data[p] = q_mem[p][rp_q[p][QA_W-1:0]];
         o_q_empty[p] = q_count(wp_q[p], rp_q[p]) == '0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int p = 0; p < NPORT; p++) begin
            wp_q[p] <= '0;
            rp_q[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            wp_q[p] <= wp_d[p];
            rp_q[p] <= rp_d[p];
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      for (int p = 0; p < NPORT; p++)
         if (q_we[p])
            q_mem[p][wp_q[p][QA_W-1:0]] <= i_chg_data;
      if (op_we)
         op_mem[op_wp_q] <= i_chg_data;
   end

   // operator copy ring, index 0 is the newest record
   always_comb begin
      op_wp_d = op_wp_q;
      op_cnt_d = op_cnt_q;
      op_we = 1'b0;
      if (i_op_clear) begin
         op_cnt_d = '0;
      end else if (i_chg_valid && i_chg_display) begin
         op_we = 1'b1; // [RQ12]
         op_wp_d = (op_wp_q == OPA_W'(OPQ_DEPTH - 1)) ? '0 : op_wp_q + 1'b1;
         if (op_cnt_q != OPA_W'(OPQ_DEPTH))
            op_cnt_d = op_cnt_q + 1'b1;
      end
      op_addr = {1'b0, op_wp_q} + (OPA_W+1)'(OPQ_DEPTH - 1) -
         {1'b0, i_op_rd_idx}; // [RQ13]
      if (op_addr >= (OPA_W+1)'(OPQ_DEPTH))
         op_addr = op_addr - (OPA_W+1)'(OPQ_DEPTH);
      op_data_d = '0;
      if (i_op_rd_idx < op_cnt_q)
         op_data_d = op_mem[op_addr[OPA_W-1:0]];
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         op_wp_q <= '0;
         op_cnt_q <= '0;
         op_data_q <= '0;
         poll_q <= '0;
      end else begin
         op_wp_q <= op_wp_d;
         op_cnt_q <= op_cnt_d;
         op_data_q <= op_data_d;
         poll_q <= i_sig_value; // [RQ14]
      end
   end

   assign o_op_data = op_data_q;
   assign o_op_count = op_cnt_q;
   assign o_poll_value = poll_q;

   default clocking top_cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_op_store;
      i_chg_valid && i_chg_display && !i_op_clear;
   endsequence
   sequence s_op_read_newest;
      i_op_rd_idx == '0 && !i_op_clear;
   endsequence

   a_fail_event: assert property ($rose(fail_q[P_REM3]) |-> // [RQ4]
         fev_q[P_REM3])
      else $error("failure alarm without event");
   a_recover_msg: assert property (msg_ok_w[P_REM3] && // [RQ16]
         fail_q[P_REM3] |=> !fail_q[P_REM3] && rev_q[P_REM3])
      else $error("valid message did not clear alarm");
   a_code_shows: assert property (act_w[P_REM2] |=> // [RQ1]
         o_remote2_activity_code)
      else $error("activity code not shown");
   a_subst_hold: assert property (act_w[P_LOCAL] |=> hold_q[P_LOCAL] == // [RQ2]
         TMR_W'($past(i_pw_timeout_min)) * TMR_W'(HOLD_MIN_MS))
      else $error("local hold not password timeout");
   a_minute_hold: assert property (act_w[P_FBUS] |=> // [RQ3]
         hold_q[P_FBUS] == TMR_W'(HOLD_MIN_MS))
      else $error("field bus hold not one minute");
   a_poll_skip: assert property (proto_w[P_REM1] == PR_POLL |=> // [RQ14]
         wp_q[P_REM1] == $past(wp_q[P_REM1]))
      else $error("polling port queued a change");
   a_queue_indep: assert property (i_q_pop[P_LOCAL] && // [RQ11]
         !i_q_pop[P_REM2] |=> rp_q[P_REM2] == $past(rp_q[P_REM2]))
      else $error("drain touched another queue");
   a_op_newest: assert property (s_op_store ##1 s_op_read_newest |=> // [RQ13]
         o_op_data == $past(i_chg_data, 2))
      else $error("newest record not shown first");
endmodule

// ---- tb/ssp_master_model.sv ----
/*
 * Behavioural master station on the local serial line.
 * Assumes the bench calls send_char and passes the bit time in clocks.
 */
`timescale 1ns/1ps
module ssp_master_model
   import ssp_pkg::*;
(
   input wire logic i_core_clk,
   output logic o_rxd
);
   // line idles high between frames, as with a pull-up
   initial o_rxd = 1'b1;

   task automatic send_char(input logic [7:0] d, input ssp_par_e par,
         input logic two, input logic bad_par, input int unsigned div);
      logic [11:0] bits;
      int n;
      bits = '1;
      bits[8:0] = {d, 1'b0}; // lsb first after start bit
      bits[9] = (^d) ^ (par == PAR_ODD) ^ bad_par;
      n = 10 + int'(par != PAR_NONE) + int'(two);
      for (int i = 0; i < n; i++) begin
         @(posedge i_core_clk);
         o_rxd <= (i == 9 && par == PAR_NONE) ? 1'b1 : bits[i];
         repeat (div - 1) @(posedge i_core_clk);
      end
   endtask
endmodule

// ---- tb/test_ssp_top.sv ----
/*
 * Self-checking bench for the serial port supervision block.
 * Assumes an ms tick every clock (CYC_MS = 1) to keep holds short.
 */
`timescale 1ns/1ps
module test_ssp_top;
   import ssp_pkg::*;
   localparam int unsigned TB_MS = 1;
   localparam int unsigned DIV = CLK_HZ / 38400;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic cfg_load = 1'b0;
   ssp_baud_e baud = BAUD_300;
   ssp_par_e par = PAR_NONE;
   logic two_stop = 1'b0;
   logic rxd;
   logic msg_done = 1'b0;
   logic [NPORT-1:0][FAIL_S_W-1:0] fail_s = '0;
   logic [NPORT-1:0] act = '0;
   logic [NPORT-1:0] msg_ok = '0;
   logic [NPORT-1:0] pop = '0;
   logic chg_v = 1'b0;
   logic chg_disp = 1'b0;
   logic [CHG_W-1:0] chg_d = '0;
   logic [CHG_W-1:0] sig = '0;
   logic [OPA_W-1:0] rd_idx = '0;
   logic op_clr = 1'b0;
   logic [7:0] rx_data;
   logic rx_valid, par_err, frame_err, abort;
   wire [4:0] codes;
   logic [NPORT-1:0] comm_fail, fail_ev, rec_ev, q_empty;
   logic [NPORT-1:0][CHG_W-1:0] q_data;
   logic [CHG_W-1:0] poll_v, op_d;
   logic [OPA_W-1:0] op_cnt;
   int mismatches = 0;
   int n_compared = 0;

   always #4 core_clk = ~core_clk;

   ssp_master_model u_master (.i_core_clk(core_clk), .o_rxd(rxd));

   ssp_top #(.CYC_MS(TB_MS)) DUT (
      .i_core_clk(core_clk), .i_resetn(resetn), .i_cfg_load(cfg_load),
      .i_local_baud(baud), .i_local_parity(par),
      .i_local_two_stop(two_stop), .i_char_gap_ms(16'h0005),
      .i_local_rxd(rxd), .i_local_msg_done(msg_done),
      .i_remote1_proto(PR_POLL), .i_remote2_proto(PR_DNP),
      .i_remote3_proto(PR_SUBST), .i_pw_timeout_min(4'h1),
      .i_fail_time_s(fail_s), .i_port_act(act), .i_port_msg_ok(msg_ok),
      .i_chg_valid(chg_v), .i_chg_data(chg_d), .i_chg_display(chg_disp),
      .i_q_pop(pop), .i_sig_value(sig), .i_op_rd_idx(rd_idx),
      .i_op_clear(op_clr), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
      .o_rx_par_err(par_err), .o_rx_frame_err(frame_err),
      .o_msg_abort(abort), .o_local_activity_code(codes[0]),
      .o_remote1_activity_code(codes[1]),
      .o_remote2_activity_code(codes[2]),
      .o_remote3_activity_code(codes[3]),
      .o_fieldbus_activity_code(codes[4]), .o_comm_fail(comm_fail),
      .o_fail_event(fail_ev), .o_recover_event(rec_ev),
      .o_q_data(q_data), .o_q_empty(q_empty), .o_poll_value(poll_v),
      .o_op_data(op_d), .o_op_count(op_cnt));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic t_hold();
      @(posedge core_clk) act <= 5'h1e;
      @(posedge core_clk) act <= '0;
      @(negedge core_clk) check(codes[4:1], 4'hf);
      repeat (60000 * TB_MS - 12) @(negedge core_clk);
      check(codes[4:1], 4'hf);
      repeat (20) @(negedge core_clk);
      check(codes[4:1], 4'h0);
   endtask

   task automatic t_fail();
      int n;
      n = 0;
      repeat (1000 * TB_MS - 20) @(negedge core_clk);
      check(comm_fail, 5'h00);
      while (fail_ev[3] !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      check(fail_ev, 5'h08);
      check(comm_fail, 5'h08);
      @(posedge core_clk) msg_ok <= 5'h08;
      @(posedge core_clk) msg_ok <= '0;
      @(negedge core_clk) check(comm_fail, 5'h00);
      check(rec_ev, 5'h08);
   endtask

   task automatic t_queue();
      @(posedge core_clk) begin
         chg_v <= 1'b1; chg_d <= 16'h1111; chg_disp <= 1'b1;
         sig <= 16'hbeef;
      end
      @(posedge core_clk) chg_d <= 16'h2222;
      @(posedge core_clk) chg_v <= 1'b0;
      @(negedge core_clk) check(q_empty, 5'h02);
      check(q_data[0], 16'h1111);
      check(poll_v, 16'hbeef);
      check(op_cnt, 7'h02);
      @(negedge core_clk) check(op_d, 16'h2222);
      @(posedge core_clk) pop <= 5'h01;
      @(posedge core_clk) pop <= '0;
      @(negedge core_clk) check(q_data[0], 16'h2222);
      @(posedge core_clk) pop <= 5'h01;
      @(posedge core_clk) begin pop <= '0; rd_idx <= 7'h01; end
      repeat (2) @(negedge core_clk);
      check(q_empty, 5'h03);
      check(q_data[2], 16'h1111);
      check(op_d, 16'h1111);
      @(posedge core_clk) rd_idx <= 7'h02;
      repeat (3) @(negedge core_clk);
      check(op_d, 16'h0000);
      @(posedge core_clk) op_clr <= 1'b1;
      @(posedge core_clk) op_clr <= 1'b0;
      @(negedge core_clk) check(op_cnt, 7'h00);
   endtask

   task automatic t_fill();
      for (int i = 1; i <= 120; i++)
         @(posedge core_clk) begin
            chg_v <= 1'b1;
            chg_d <= CHG_W'(i);
         end
      @(posedge core_clk) begin
         chg_v <= 1'b0;
         rd_idx <= '0;
      end
      repeat (2) @(negedge core_clk);
      check(op_cnt, 7'h73);
      check(op_d, 16'h0078);
      check(q_data[0], 16'h0001);
      check(q_data[2], 16'h1111);
   endtask

   task automatic one_char(input logic [7:0] d, input logic bad, output int ab);
      int n;
      n = 0;
      ab = -1;
      fork
         u_master.send_char(d, par, two_stop, bad, DIV);
         while (rx_valid !== 1'b1 && n < 50000) begin
            @(negedge core_clk);
            n++;
         end
      join_any
      check(rx_data, d);
      check(par_err, bad);
      check(frame_err, 1'b0);
      if (bad) begin
         @(posedge core_clk) msg_done <= 1'b1;
         @(posedge core_clk) msg_done <= 1'b0;
      end
      for (int i = 1; i <= 30; i++) begin
         @(negedge core_clk);
         if (i == 1)
            check(codes[0], 1'b1);
         if (abort === 1'b1 && ab < 0) ab = i;
      end
      wait fork;
   endtask

   task automatic t_char();
      int ab;
      one_char(8'h5a, 1'b0, ab);
      check(ab >= 8 && ab <= 20, 1'b1);
      @(posedge core_clk) begin
         par <= PAR_EVEN; two_stop <= 1'b1; cfg_load <= 1'b1;
         baud <= BAUD_38400;
      end
      @(posedge core_clk) cfg_load <= 1'b0;
      one_char(8'ha5, 1'b1, ab);
      check(ab, -1);
   endtask

   initial begin
      fail_s[3] = 10'h001;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      @(negedge core_clk) check(codes, 5'h00);
      check(q_empty, 5'h1f);
      fork
         t_hold();
         t_fail();
         begin
            t_queue();
            t_fill();
            t_char();
         end
      join
      report_and_stop();
   end

   initial begin
      repeat (90000) @(posedge core_clk);
      mismatches++;
      report_and_stop();
   end
endmodule
